// >>> common/lcdc_pkg.sv
// shared constants, register map and field layouts of the lcd driver configuration block
package lcdc_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int BASE_FAST_HZ = 2048;
	localparam int BASE_SLOW_HZ = 128;
	localparam int BLINK_STEP_MS = 250;
	localparam int FAST_DIV = CLK_HZ / BASE_FAST_HZ;
	localparam int SLOW_DIV = CLK_HZ / BASE_SLOW_HZ;
	localparam int BLINK_STEP_DIV = (CLK_HZ / 1000) * BLINK_STEP_MS;
	localparam int PHASE_TICKS = 8;

	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_MAIN = 8'h95;
	localparam logic [7:0] ADDR_LADDER = 8'h9c;
	localparam logic [7:0] ADDR_FRAME = 8'hb1;

	// ==========================================================
	// field positions and reset values
	localparam int LADDER_EN_BIT = 6;
	localparam int FRAME_INV_BIT = 6;
	localparam int FRAME_UPD_BIT = 1;
	localparam int FRAME_REFRESH_BIT = 0;
	localparam logic [7:0] MAIN_RST = 8'h00;
	localparam logic LADDER_EN_RST = 1'b0;
	localparam logic FRAME_INV_RST = 1'b0;
	localparam logic FRAME_REFRESH_RST = 1'b0;
	localparam logic FRAME_UPD_RST = 1'b0;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		MUX_RSVD = 2'h0,
		MUX_2X = 2'h1,
		MUX_3X = 2'h2,
		MUX_4X = 2'h3
	} lcdc_mux_t;

	typedef enum logic [1:0] {
		BLK_SW_OFF = 2'h0,
		BLK_SW_ON = 2'h1,
		BLK_FIXED = 2'h2,
		BLK_RATE = 2'h3
	} lcdc_blink_src_t;

	// main configuration register, msb first as laid out in the byte
	typedef struct packed {
		logic panel_driver_enable;
		logic segment_data_clear;
		logic blink_enable;
		logic sleep_force_off;
		logic panel_clock_select;
		logic bias_third;
		lcdc_mux_t multiplex_level;
	} lcdc_main_cfg_t;
endpackage

// >>> verilog/lcdc_tick_div.sv
// free-running clock divider giving a one-cycle tick every DIV cycles while enabled
`timescale 1ns/10ps
module lcdc_tick_div #(
	parameter int DIV = 2
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_run,
	output logic o_tick
);
	localparam int W = $clog2(DIV + 1);

	if (DIV < 1) begin : g_chk
		$error("lcdc_tick_div: DIV must be at least one");
	end

	logic [W-1:0] cnt_r;

	// ==========================================================
	// divider
	// the count restarts while stopped so the first tick after a start is a whole period away
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_r <= '0;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			cnt_r <= '0;
			o_tick <= 1'b0;
		end else if (cnt_r == W'(DIV - 1)) begin
			cnt_r <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + W'(1);
			o_tick <= 1'b0;
		end
	end
endmodule

// >>> verilog/lcdc_config.sv
// lcd driver configuration registers, timebase, blink, frame inversion and refresh handshake
// ==========================================================
`timescale 1ns/10ps
module lcdc_config #(
	parameter int FAST_DIV = lcdc_pkg::FAST_DIV,
	parameter int SLOW_DIV = lcdc_pkg::SLOW_DIV,
	parameter int BLINK_STEP_DIV = lcdc_pkg::BLINK_STEP_DIV,
	parameter int PHASE_TICKS = lcdc_pkg::PHASE_TICKS
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	output logic [7:0] o_sfr_rdata,
	input wire logic i_sleep_power_mode,
	input wire lcdc_pkg::lcdc_blink_src_t i_blink_source,
	input wire logic [1:0] i_blink_rate,
	output logic o_driver_active,
	output logic o_display_on,
	output logic o_seg_data_clear,
	output logic o_base_tick,
	output logic o_frame_start,
	output logic o_frame_invert,
	output logic o_data_take,
	output logic o_ladder_short,
	output logic o_ladder_enable,
	output logic o_pin_a_com,
	output logic o_pin_b_com
);
	if (PHASE_TICKS < 1 || PHASE_TICKS > 255) begin : g_chk
		$error("lcdc_config: PHASE_TICKS must be 1 to 255");
	end

	lcdc_pkg::lcdc_main_cfg_t main_r;
	logic ladder_en_r;
	logic inv_en_r;
	logic refresh_r;
	logic upd_flag_r;
	logic sleep_meta_r;
	logic sleep_sync_r;
	logic fast_tick;
	logic slow_tick;
	logic step_tick;
	logic base_tick;
	logic frame_start;
	logic [9:0] frame_cnt_r;
	logic [9:0] frame_len;
	logic [2:0] com_count;
	logic [2:0] blink_cnt_r;
	logic [3:0] half_steps;
	logic blink_phase_r;
	logic wr_main;
	logic wr_ladder;
	logic wr_frame;

	assign wr_main = i_sfr_wr && (i_sfr_addr == lcdc_pkg::ADDR_MAIN);
	assign wr_ladder = i_sfr_wr && (i_sfr_addr == lcdc_pkg::ADDR_LADDER);
	assign wr_frame = i_sfr_wr && (i_sfr_addr == lcdc_pkg::ADDR_FRAME);

	// ==========================================================
	// register writes
	// reserved bits are not stored, so they always read back as zero
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			main_r <= lcdc_pkg::lcdc_main_cfg_t'(lcdc_pkg::MAIN_RST);
			ladder_en_r <= lcdc_pkg::LADDER_EN_RST;
			inv_en_r <= lcdc_pkg::FRAME_INV_RST;
			refresh_r <= lcdc_pkg::FRAME_REFRESH_RST;
		end else begin
			if (wr_main) begin
				main_r <= lcdc_pkg::lcdc_main_cfg_t'(i_sfr_wdata);
			end
			if (wr_ladder) begin
				ladder_en_r <= i_sfr_wdata[lcdc_pkg::LADDER_EN_BIT];
			end
			if (wr_frame) begin
				inv_en_r <= i_sfr_wdata[lcdc_pkg::FRAME_INV_BIT];
				refresh_r <= i_sfr_wdata[lcdc_pkg::FRAME_REFRESH_BIT];
			end
		end
	end

	// ==========================================================
	// register reads, one cycle after the read strobe
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_sfr_rd) begin
			if (i_sfr_addr == lcdc_pkg::ADDR_MAIN) begin
				o_sfr_rdata <= main_r;
			end else if (i_sfr_addr == lcdc_pkg::ADDR_LADDER) begin
				o_sfr_rdata <= 8'(ladder_en_r) << lcdc_pkg::LADDER_EN_BIT;
			end else if (i_sfr_addr == lcdc_pkg::ADDR_FRAME) begin
				o_sfr_rdata <= (8'(inv_en_r) << lcdc_pkg::FRAME_INV_BIT)
					| (8'(upd_flag_r) << lcdc_pkg::FRAME_UPD_BIT)
					| (8'(refresh_r) << lcdc_pkg::FRAME_REFRESH_BIT);
			end else begin
				o_sfr_rdata <= 8'h00;
			end
		end
	end

	// ==========================================================
	// sleep indication comes from the power manager, outside this clock domain
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sleep_meta_r <= 1'b0;
			sleep_sync_r <= 1'b0;
		end else begin
			sleep_meta_r <= i_sleep_power_mode;
			sleep_sync_r <= sleep_meta_r;
		end
	end

	// ==========================================================
	// static drive controls
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_driver_active <= 1'b0;
		end else begin
			o_driver_active <= main_r.panel_driver_enable && !(sleep_sync_r && main_r.sleep_force_off);
		end
	end

	assign o_seg_data_clear = main_r.segment_data_clear;
	assign o_ladder_short = !main_r.bias_third;
	assign o_ladder_enable = ladder_en_r;
	assign o_pin_a_com = (main_r.multiplex_level == lcdc_pkg::MUX_4X);
	assign o_pin_b_com = main_r.multiplex_level[1];

	// ==========================================================
	// timebase; the dividers stop while the driver is off to save power
	lcdc_tick_div #(.DIV(FAST_DIV)) u_fast (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_run(o_driver_active),
		.o_tick(fast_tick)
	);
	lcdc_tick_div #(.DIV(SLOW_DIV)) u_slow (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_run(o_driver_active),
		.o_tick(slow_tick)
	);
	lcdc_tick_div #(.DIV(BLINK_STEP_DIV)) u_step (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_run(o_driver_active),
		.o_tick(step_tick)
	);

	assign base_tick = main_r.panel_clock_select ? slow_tick : fast_tick;
	assign o_base_tick = base_tick;

	// ==========================================================
	// frame counter; the reserved level 00 is run as 2x so the frame still advances
	always_comb begin
		case (main_r.multiplex_level)
			lcdc_pkg::MUX_3X: com_count = 3'h3;
			lcdc_pkg::MUX_4X: com_count = 3'h4;
			default: com_count = 3'h2;
		endcase
		frame_len = 10'(PHASE_TICKS * int'(com_count));
	end

	assign frame_start = o_driver_active && base_tick && (frame_cnt_r == frame_len - 10'h1);

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			frame_cnt_r <= 10'h0;
			o_frame_start <= 1'b0;
		end else if (!o_driver_active) begin
			frame_cnt_r <= 10'h0;
			o_frame_start <= 1'b0;
		end else begin
			if (frame_start || frame_cnt_r >= frame_len) begin
				frame_cnt_r <= 10'h0;
			end else if (base_tick) begin
				frame_cnt_r <= frame_cnt_r + 10'h1;
			end
			o_frame_start <= frame_start;
		end
	end

	// ==========================================================
	// frame inversion
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_frame_invert <= 1'b0;
		end else if (!inv_en_r) begin
			o_frame_invert <= 1'b0;
		end else if (frame_start) begin
			o_frame_invert <= !o_frame_invert;
		end
	end

	// ==========================================================
	// refresh handshake; a new frame set wins over a software clear in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_data_take <= 1'b0;
			upd_flag_r <= lcdc_pkg::FRAME_UPD_RST;
		end else begin
			o_data_take <= frame_start && !refresh_r;
			if (frame_start && !refresh_r) begin
				upd_flag_r <= 1'b1;
			end else if (wr_frame && !i_sfr_wdata[lcdc_pkg::FRAME_UPD_BIT]) begin
				upd_flag_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// blink; steps are quarter seconds, half period in steps per source and rate
	always_comb begin
		if (i_blink_source == lcdc_pkg::BLK_FIXED) begin
			half_steps = 4'h1;
		end else begin
			half_steps = {1'b0, i_blink_rate, 1'b0} + 4'h2;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			blink_cnt_r <= 3'h0;
			blink_phase_r <= 1'b1;
		end else if (!main_r.blink_enable || !i_blink_source[1]) begin
			blink_cnt_r <= 3'h0;
			blink_phase_r <= 1'b1;
		end else if (step_tick) begin
			if ({1'b0, blink_cnt_r} + 4'h1 >= half_steps) begin
				blink_cnt_r <= 3'h0;
				blink_phase_r <= !blink_phase_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 3'h1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_display_on <= 1'b0;
		end else if (!main_r.blink_enable) begin
			o_display_on <= o_driver_active;
		end else if (i_blink_source == lcdc_pkg::BLK_SW_OFF) begin
			o_display_on <= 1'b0;
		end else begin
			o_display_on <= o_driver_active && (i_blink_source == lcdc_pkg::BLK_SW_ON || blink_phase_r);
		end
	end

	// ==========================================================
	// checks
	a_enable_runs: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		wr_main && i_sfr_wdata[7] && !i_sfr_wdata[4] |=> ##1 o_driver_active)
		else $error("driver not active after enable write");
	a_clear_follows: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		wr_main |=> o_seg_data_clear == $past(i_sfr_wdata[6]))
		else $error("segment clear does not follow bit 6");
	a_sleep_blanks: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		sleep_sync_r && main_r.sleep_force_off && $past(sleep_sync_r && main_r.sleep_force_off)
		|=> !o_driver_active && !o_display_on)
		else $error("panel on in sleep with force-off");
	a_base_select: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		main_r.panel_clock_select && fast_tick && !slow_tick |-> !o_base_tick)
		else $error("fast tick used with slow clock selected");
	a_bias_join: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		wr_main |=> o_ladder_short != $past(i_sfr_wdata[2]))
		else $error("ladder join does not follow bias bit");
	a_pin_roles: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		wr_main && i_sfr_wdata[1:0] == 2'h2 |=> !o_pin_a_com && o_pin_b_com)
		else $error("3x pin roles wrong");
	a_ladder_on: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		wr_ladder |=> o_ladder_enable == $past(i_sfr_wdata[6]))
		else $error("ladder enable does not follow bit 6");
	a_invert_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		inv_en_r && frame_start |=> o_frame_invert != $past(o_frame_invert))
		else $error("frame inversion missed a frame");
	a_refresh_holds: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		refresh_r |=> !o_data_take)
		else $error("data taken while refresh set");
	a_update_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		frame_start && !refresh_r |=> o_data_take && o_frame_start && upd_flag_r)
		else $error("update flag not set at frame start");
	a_blink_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		main_r.blink_enable && i_blink_source == lcdc_pkg::BLK_FIXED && step_tick
		&& $stable(i_blink_source) |=> blink_phase_r != $past(blink_phase_r))
		else $error("fixed blink did not toggle each step");
endmodule

// >>> verif/lcdc_panel_model.sv
// behavioural multiplexed lcd panel: counts frames and records drive polarity
`timescale 1ns/10ps
module lcdc_panel_model (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_frame_start,
	input wire logic i_frame_invert,
	output int o_frames,
	output logic [1:0] o_inv_hist
);
	logic fs_d1_r;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			fs_d1_r <= 1'b0;
			o_frames <= 0;
			o_inv_hist <= 2'h0;
		end else begin
			fs_d1_r <= i_frame_start;
			if (i_frame_start) begin
				o_frames <= o_frames + 1;
			end
			// polarity has already changed when the frame start is seen; it is recorded one cycle later
			if (fs_d1_r) begin
				o_inv_hist <= {o_inv_hist[0], i_frame_invert};
			end
		end
	end
endmodule

// >>> verif/lcdc_config_bench.sv
// self-checking bench for the lcd driver configuration block
`timescale 1ns/10ps
module lcdc_config_bench;
	// ==========================================================
	// short counts keep the run small
	localparam int FDIV = 4;
	localparam int SDIV = 16;
	localparam int BDIV = 20;
	localparam int PH = 2;
	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep = 1'b0;
	lcdc_pkg::lcdc_blink_src_t bsrc = lcdc_pkg::BLK_SW_OFF;
	logic [1:0] brate = 2'h0;
	logic [7:0] rdata;
	logic act, on, clr, tick, fs, inv, take, lshort, len, pa, pb;
	logic [1:0] inv_hist;
	int frames;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	int seed = 32'h7ca8;
	int t0;
	logic [7:0] d;
	logic [7:0] v;
	logic [7:0] amap [4] = '{8'h95, 8'h9c, 8'hb1, 8'h33};
	always #10 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) cyc <= cyc + 1;
	lcdc_config #(.FAST_DIV(FDIV), .SLOW_DIV(SDIV), .BLINK_STEP_DIV(BDIV), .PHASE_TICKS(PH)) i_dut (
		.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
		.i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_sleep_power_mode(sleep),
		.i_blink_source(bsrc), .i_blink_rate(brate), .o_driver_active(act), .o_display_on(on),
		.o_seg_data_clear(clr), .o_base_tick(tick), .o_frame_start(fs), .o_frame_invert(inv),
		.o_data_take(take), .o_ladder_short(lshort), .o_ladder_enable(len), .o_pin_a_com(pa),
		.o_pin_b_com(pb)
	);
	lcdc_panel_model i_panel (
		.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_frame_start(fs), .i_frame_invert(inv),
		.o_frames(frames), .o_inv_hist(inv_hist)
	);
	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] val);
		@(posedge i_clk_sys);
		addr <= a;
		wdata <= val;
		wr <= 1'b1;
		@(posedge i_clk_sys);
		wr <= 1'b0;
		#1;
	endtask
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] val);
		@(posedge i_clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk_sys);
		rd <= 1'b0;
		#1 val = rdata;
	endtask
	// k: 0 base tick, 1 frame start, 2 display change
	task automatic wait_ev(input int k, input int bound);
		logic prev;
		prev = on;
		for (int n = 0; n <= bound; n++) begin
			@(posedge i_clk_sys);
			#1;
			if ((k == 0 && tick === 1'b1) || (k == 1 && fs === 1'b1) || (k == 2 && on !== prev))
				return;
		end
		err_count++;
		$display("unexpected at %0t: wait %0d ran out", $time, k);
		tally_and_finish();
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			sfr_rd(amap[i], v);
			check(v, 8'h00);
		end
		check({lshort, pa, pb, act}, 4'h8);
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			d[1:0] = (d[1:0] == 2'h0) ? 2'h1 : d[1:0];
			sfr_wr(lcdc_pkg::ADDR_MAIN, d);
			sfr_rd(lcdc_pkg::ADDR_MAIN, v);
			check(v, d);
			check(lshort, !d[2]);
			check({pa, pb}, {d[1:0] == 2'h3, d[1]});
			check(clr, d[6]);
		end
		$display("main register done");
		sfr_wr(lcdc_pkg::ADDR_MAIN, 8'h01);
		sfr_wr(lcdc_pkg::ADDR_LADDER, 8'h7f);
		sfr_rd(lcdc_pkg::ADDR_LADDER, v);
		check(v, 8'h40);
		check(len, 1'b1);
		sfr_wr(lcdc_pkg::ADDR_LADDER, 8'h00);
		check(len, 1'b0);
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'h00); // drop any update flag left from the random runs
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'hbe);
		sfr_rd(lcdc_pkg::ADDR_FRAME, v);
		check(v, 8'h00);
		t0 = frames;
		idle(100);
		check(frames - t0, 0);
		$display("ladder, reserved and disable done");
		for (int cs = 0; cs < 2; cs++) begin
			for (int m = 1; m < 4; m++) begin
				sfr_wr(lcdc_pkg::ADDR_MAIN, 8'(8'h80 + cs * 8 + m));
				wait_ev(0, 100);
				t0 = cyc;
				wait_ev(0, 100);
				check(cyc - t0, cs ? SDIV : FDIV);
				wait_ev(1, 800);
				t0 = cyc;
				wait_ev(1, 800);
				check(cyc - t0, (cs ? SDIV : FDIV) * PH * (m + 1));
			end
		end
		$display("clock and multiplex timing done");
		sfr_wr(lcdc_pkg::ADDR_MAIN, 8'h81);
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'h01);
		wait_ev(1, 100);
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'h01);
		wait_ev(1, 100);
		check(take, 1'b0);
		sfr_rd(lcdc_pkg::ADDR_FRAME, v);
		check(v, 8'h01);
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'h00);
		wait_ev(1, 100);
		check(take, 1'b1);
		sfr_rd(lcdc_pkg::ADDR_FRAME, v);
		check(v, 8'h02);
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'h00);
		sfr_rd(lcdc_pkg::ADDR_FRAME, v);
		check(v, 8'h00);
		$display("refresh handshake done");
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'h40);
		repeat (3) wait_ev(1, 100);
		idle(3);
		check(inv_hist[0] ^ inv_hist[1], 1'b1);
		sfr_wr(lcdc_pkg::ADDR_FRAME, 8'h00);
		repeat (2) wait_ev(1, 100);
		idle(3);
		check({inv, inv_hist}, 3'h0);
		$display("frame inversion done");
		@(posedge i_clk_sys);
		sleep <= 1'b1;
		sfr_wr(lcdc_pkg::ADDR_MAIN, 8'h91);
		idle(6);
		check(act, 1'b0);
		sfr_wr(lcdc_pkg::ADDR_MAIN, 8'h81);
		idle(6);
		check(act, 1'b1);
		@(posedge i_clk_sys);
		sleep <= 1'b0;
		$display("sleep force done");
		sfr_wr(lcdc_pkg::ADDR_MAIN, 8'ha1);
		for (int s = 0; s < 2; s++) begin
			@(posedge i_clk_sys);
			bsrc <= lcdc_pkg::lcdc_blink_src_t'(s);
			idle(4);
			check(on, s);
		end
		for (int k = 0; k < 5; k++) begin
			@(posedge i_clk_sys);
			bsrc <= (k == 0) ? lcdc_pkg::BLK_FIXED : lcdc_pkg::BLK_RATE;
			brate <= 2'(k - 1);
			wait_ev(2, 400);
			wait_ev(2, 400);
			t0 = cyc;
			wait_ev(2, 400);
			check(cyc - t0, (k == 0) ? BDIV : 2 * k * BDIV);
		end
		@(posedge i_clk_sys);
		bsrc <= lcdc_pkg::BLK_SW_OFF;
		sfr_wr(lcdc_pkg::ADDR_MAIN, 8'h81);
		idle(4);
		check(on, 1'b1);
		$display("blink done");
		tally_and_finish();
	end
endmodule
